// ===== core/acsr_regs.sv
// Register bank for indicator, reference calibration and scan sequence table
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns

// Operation
// RULE_01: A one in bit 0 of the indicator control register lights the front panel indicator.
// RULE_02: A zero in bit 0 of the indicator control register turns the indicator off.
// RULE_03: Writing a one to the step bit during calibration advances to the next reference voltage.
// RULE_04: The signal processor clears the step bit after acting on it.
// RULE_05: During calibration the reference output follows the 16-bit code register.
// RULE_06: The code is straight binary spanning zero to ten volts.
// RULE_07: The low four bits of the status register show the current reference step.
// RULE_08: Status bits 15 to 4 are reserved and carry nothing.
// RULE_09: Calibration under software control is allowed only with the right 32-bit key in two halves.
// RULE_10: A table of 256 byte-wide read/write entries sits at consecutive byte addresses.
// RULE_11: The scan order comes from the table only while the table enable is one.
// RULE_12: An entry with bit 7 set is the last entry of the sequence.
// RULE_13: Software keeps the table length a power of two and within the buffer size.
// RULE_14: The low four bits of an entry select the channel converted there.
// RULE_15: Software writes zeros to entry bits 6 to 4.
// RULE_16: After the last marked entry the scan restarts at the first entry.
module acsr_regs
    import acsr_pkg::*;
#(
    parameter logic [31:0] UNLOCK_KEY = 32'h1234_abcd, // Arbitrary value
    parameter int NUM_CHANNELS = ACSR_NUM_CHANNELS
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Register port
    input wire logic [ACSR_AW-1:0] reg_addr,
    input wire logic [ACSR_DW-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [ACSR_DW-1:0] reg_rdata,
    // Front panel
    output logic indicator_on,
    // Signal processor side of calibration
    input wire logic reference_step_ack,
    output logic reference_step,
    output logic cal_unlocked,
    output logic [ACSR_DW-1:0] reference_output_code,
    output logic [ACSR_STEP_INDEX_W-1:0] reference_step_index,
    // Scan sequencing
    input wire logic sequence_table_enable,
    input wire logic conv_done,
    output logic [ACSR_CHSEL_W-1:0] channel_select,
    output logic table_last_entry
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic indicator_q;
    logic step_q;
    acsr_step_state_t step_state_q;
    logic [ACSR_DW-1:0] code_q;
    logic [ACSR_STEP_INDEX_W-1:0] index_q;
    logic [ACSR_DW-1:0] key_hi_q;
    logic [ACSR_DW-1:0] key_lo_q;
    logic unlocked_q;
    logic [ACSR_DW-1:0] out_code_q;
    logic [ACSR_DW-1:0] rdata_q;
    logic [ACSR_DW-1:0] rdata_d;
    logic wr_step;
    logic step_set;
    logic wr_ind;
    logic wr_code;
    logic wr_key_hi;
    logic wr_key_lo;
    logic wr_status;

    // Carrier to the scan table
    acsr_tbl_if tbl ();

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    // Write strobe aimed at one register offset
    function automatic logic wr_hit(input logic wr, input logic [ACSR_AW-1:0] addr,
                                    input logic [ACSR_AW-1:0] off);
        return wr && (addr == off);
    endfunction

    // One decode per writable register
    assign wr_ind = wr_hit(reg_write, reg_addr, ACSR_OFF_INDICATOR);
    assign wr_step = wr_hit(reg_write, reg_addr, ACSR_OFF_STEP_CMD);
    assign wr_code = wr_hit(reg_write, reg_addr, ACSR_OFF_CODE);
    assign wr_key_hi = wr_hit(reg_write, reg_addr, ACSR_OFF_KEY_HI);
    assign wr_key_lo = wr_hit(reg_write, reg_addr, ACSR_OFF_KEY_LO);
    assign wr_status = wr_hit(reg_write, reg_addr, ACSR_OFF_STATUS);
    // RULE_03: advance accepted only while unlocked
    assign step_set = wr_step && reg_wdata[ACSR_STEP_BIT] && unlocked_q;

    // Indicator control
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            indicator_q <= 1'b0;
        end
        else if (wr_ind)
        begin
            // RULE_01: one lights the indicator
            // RULE_02: zero turns it off
            indicator_q <= reg_wdata[ACSR_INDICATOR_ON_BIT];
        end
    end

    // Calibration output code
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            code_q <= ACSR_RST_WORD;
        end
        else if (wr_code)
        begin
            code_q <= reg_wdata;
        end
    end

    // Upper key half
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            key_hi_q <= ACSR_RST_WORD;
        end
        else if (wr_key_hi)
        begin
            key_hi_q <= reg_wdata;
        end
    end

    // Lower key half
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            key_lo_q <= ACSR_RST_WORD;
        end
        else if (wr_key_lo)
        begin
            key_lo_q <= reg_wdata;
        end
    end

    // Key comparison
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            unlocked_q <= 1'b0;
        end
        else
        begin
            // RULE_09: both halves must match the key
            unlocked_q <= ({key_hi_q, key_lo_q} == UNLOCK_KEY);
        end
    end

    // ------------------------------------------------------------
    // Step request handshake
    // ------------------------------------------------------------
    // Software sets the bit, the processor ack clears it
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            step_q <= 1'b0;
            step_state_q <= ACSR_STEP_IDLE;
        end
        else
        begin
            unique case (step_state_q)
                ACSR_STEP_IDLE:
                begin
                    if (step_set)
                    begin
                        step_q <= 1'b1;
                        step_state_q <= ACSR_STEP_WAIT;
                    end
                end
                ACSR_STEP_WAIT:
                begin
                    // RULE_04: processor clears the bit; a new set wins
                    if (reference_step_ack && !step_set)
                    begin
                        step_q <= 1'b0;
                        step_state_q <= ACSR_STEP_IDLE;
                    end
                end
            endcase
        end
    end

    // Current reference step
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            index_q <= ACSR_RST_STEP_INDEX;
        end
        else if ((step_state_q == ACSR_STEP_WAIT) && reference_step_ack)
        begin
            // RULE_07: step index follows each acted advance
            index_q <= index_q + ACSR_STEP_INDEX_INC;
        end
        else if (wr_status)
        begin
            index_q <= reg_wdata[ACSR_STEP_INDEX_W-1:0];
        end
    end

    // Reference output drive
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            out_code_q <= ACSR_RST_WORD;
        end
        else
        begin
            // RULE_05: code drives output while unlocked
            // RULE_06: straight binary, passed unchanged
            out_code_q <= unlocked_q ? code_q : ACSR_RST_WORD;
        end
    end

    // ------------------------------------------------------------
    // Scan table hookup
    // ------------------------------------------------------------
    assign tbl.wr = reg_write && acsr_is_table(reg_addr);
    assign tbl.addr = acsr_table_index(reg_addr);
    assign tbl.wdata = reg_wdata[ACSR_ENTRY_W-1:0];
    // RULE_11: enable steers table order
    assign tbl.enable = sequence_table_enable;
    assign tbl.advance = conv_done;

    acsr_seq_table #(
        .DEPTH(ACSR_TABLE_DEPTH),
        .NUM_CHANNELS(NUM_CHANNELS)
    ) u_table (
        .clock(clock),
        .resetn(resetn),
        .tbl(tbl)
    );

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Read mux by offset, unused bits read zero
    always_comb
    begin
        rdata_d = ACSR_RST_WORD;
        if (acsr_is_table(reg_addr))
        begin
            rdata_d = {8'h00, tbl.rdata};
        end
        else
        begin
            unique case (reg_addr)
                ACSR_OFF_INDICATOR: rdata_d[ACSR_INDICATOR_ON_BIT] = indicator_q;
                ACSR_OFF_STEP_CMD: rdata_d[ACSR_STEP_BIT] = step_q;
                ACSR_OFF_CODE: rdata_d = code_q;
                // RULE_08: upper status bits read zero
                ACSR_OFF_STATUS: rdata_d[ACSR_STEP_INDEX_W-1:0] = index_q;
                ACSR_OFF_KEY_HI: rdata_d = key_hi_q;
                ACSR_OFF_KEY_LO: rdata_d = key_lo_q;
                default: rdata_d = ACSR_RST_WORD; // Unmapped reads zero
            endcase
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            rdata_q <= ACSR_RST_WORD;
        end
        else if (reg_read)
        begin
            rdata_q <= rdata_d;
        end
        else
        begin
            rdata_q <= ACSR_RST_WORD;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = rdata_q;
    assign indicator_on = indicator_q;
    assign reference_step = step_q;
    assign cal_unlocked = unlocked_q;
    assign reference_output_code = out_code_q;
    assign reference_step_index = index_q;
    assign channel_select = tbl.channel;
    assign table_last_entry = tbl.last;

endmodule // acsr_regs

// ===== core/acsr_pkg.sv
// Constants, types and decode helpers for the calibration and scan register bank
package acsr_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ACSR_AW = 12;
    localparam int ACSR_DW = 16;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ACSR_OFF_INDICATOR = 12'h030;
    localparam logic [11:0] ACSR_OFF_STEP_CMD = 12'h040;
    localparam logic [11:0] ACSR_OFF_CODE = 12'h042;
    localparam logic [11:0] ACSR_OFF_STATUS = 12'h044;
    localparam logic [11:0] ACSR_OFF_KEY_HI = 12'h046;
    localparam logic [11:0] ACSR_OFF_KEY_LO = 12'h048;
    localparam logic [11:0] ACSR_OFF_TABLE_BASE = 12'h400;
    localparam logic [11:0] ACSR_OFF_TABLE_LAST = 12'h4ff;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int ACSR_INDICATOR_ON_BIT = 0;
    localparam int ACSR_STEP_BIT = 0;
    localparam int ACSR_STEP_INDEX_W = 4;
    localparam int ACSR_LAST_ENTRY_BIT = 7;
    localparam int ACSR_CHSEL_W = 4;
    localparam int ACSR_ENTRY_W = 8;
    localparam int ACSR_TABLE_DEPTH = 256;
    localparam int ACSR_TABLE_AW = 8;
    localparam int ACSR_NUM_CHANNELS = 16;

    // ------------------------------------------------------------
    // Reset values and increments
    // ------------------------------------------------------------
    localparam logic [15:0] ACSR_RST_WORD = 16'h0000;
    localparam logic [3:0] ACSR_RST_STEP_INDEX = 4'h0;
    localparam logic [7:0] ACSR_RST_ENTRY = 8'h00;
    localparam logic [7:0] ACSR_RST_PTR = 8'h00;
    localparam logic [3:0] ACSR_STEP_INDEX_INC = 4'h1;
    localparam logic [7:0] ACSR_PTR_INC = 8'h01;

    // Advance handshake towards the signal processor
    typedef enum logic [0:0] {
        ACSR_STEP_IDLE,
        ACSR_STEP_WAIT
    } acsr_step_state_t;

    // True for any byte address inside the scan table window
    function automatic logic acsr_is_table(input logic [11:0] addr);
        return (addr >= ACSR_OFF_TABLE_BASE) && (addr <= ACSR_OFF_TABLE_LAST);
    endfunction

    // Entry index of a table address
    function automatic logic [7:0] acsr_table_index(input logic [11:0] addr);
        return addr[7:0];
    endfunction

endpackage

// ===== core/acsr_tbl_if.sv
// Carrier between the register bank and the scan sequence table
`timescale 1ns/1ns
interface acsr_tbl_if;
    import acsr_pkg::*;

    // Bus access to the table
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    // Scan stepping
    logic enable;
    logic advance;
    logic [3:0] channel;
    logic last;

    modport regs (
        output wr,
        output addr,
        output wdata,
        input rdata,
        output enable,
        output advance,
        input channel,
        input last
    );

    modport store (
        input wr,
        input addr,
        input wdata,
        output rdata,
        input enable,
        input advance,
        output channel,
        output last
    );
endinterface

// ===== core/acsr_seq_table.sv
// Scan sequence table storage and scan pointer
`timescale 1ns/1ns
module acsr_seq_table
    import acsr_pkg::*;
#(
    parameter int DEPTH = ACSR_TABLE_DEPTH,
    parameter int NUM_CHANNELS = ACSR_NUM_CHANNELS
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Table and scan carrier
    acsr_tbl_if.store tbl
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [ACSR_ENTRY_W-1:0] mem_q [DEPTH];
    logic [ACSR_TABLE_AW-1:0] ptr_q;
    logic en_q;
    logic [ACSR_CHSEL_W-1:0] channel_q;
    logic last_q;
    logic [ACSR_ENTRY_W-1:0] cur_entry;

    // Entry under the scan pointer
    assign cur_entry = mem_q[ptr_q];
    assign tbl.rdata = mem_q[tbl.addr];

    // Byte-wide writable entries
    // RULE_10: table entry storage
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_q[i] <= ACSR_RST_ENTRY;
            end
        end
        else if (tbl.wr)
        begin
            mem_q[tbl.addr] <= tbl.wdata;
        end
    end

    // ------------------------------------------------------------
    // Scan pointer
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            ptr_q <= ACSR_RST_PTR;
            en_q <= 1'b0;
        end
        else
        begin
            en_q <= tbl.enable;
            if (tbl.enable != en_q)
            begin
                ptr_q <= ACSR_RST_PTR; // Mode change restarts the scan
            end
            else if (tbl.advance)
            begin
                if (tbl.enable)
                begin
                    // RULE_12: marked entry ends sequence
                    // RULE_16: wrap to first entry
                    if (cur_entry[ACSR_LAST_ENTRY_BIT] || (int'(ptr_q) == DEPTH - 1))
                    begin
                        ptr_q <= ACSR_RST_PTR;
                    end
                    else
                    begin
                        ptr_q <= ptr_q + ACSR_PTR_INC;
                    end
                end
                else if (int'(ptr_q) >= NUM_CHANNELS - 1)
                begin
                    ptr_q <= ACSR_RST_PTR;
                end
                else
                begin
                    ptr_q <= ptr_q + ACSR_PTR_INC;
                end
            end
        end
    end

    // Channel in use and end marker
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            channel_q <= '0;
            last_q <= 1'b0;
        end
        else if (tbl.enable)
        begin
            // RULE_11: order from table
            // RULE_14: low nibble picks channel
            channel_q <= cur_entry[ACSR_CHSEL_W-1:0];
            last_q <= cur_entry[ACSR_LAST_ENTRY_BIT];
        end
        else
        begin
            channel_q <= ptr_q[ACSR_CHSEL_W-1:0]; // Natural order
            last_q <= (int'(ptr_q) >= NUM_CHANNELS - 1);
        end
    end

    assign tbl.channel = channel_q;
    assign tbl.last = last_q;

endmodule // acsr_seq_table

// ===== test/acsr_regs_sva.sv
// Assertion checker for the calibration and scan register bank
`timescale 1ns/1ns
module acsr_regs_sva
    import acsr_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Register port
    input wire logic [ACSR_AW-1:0] reg_addr,
    input wire logic [ACSR_DW-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [ACSR_DW-1:0] reg_rdata,
    // Front panel
    input wire logic indicator_on,
    // Calibration
    input wire logic reference_step_ack,
    input wire logic reference_step,
    input wire logic cal_unlocked,
    input wire logic [ACSR_DW-1:0] reference_output_code,
    input wire logic [ACSR_STEP_INDEX_W-1:0] reference_step_index,
    // Scan
    input wire logic sequence_table_enable,
    input wire logic conv_done,
    input wire logic [ACSR_CHSEL_W-1:0] channel_select,
    input wire logic table_last_entry
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    // Write decodes
    wire logic wr_ind = reg_write && (reg_addr == ACSR_OFF_INDICATOR);
    wire logic wr_stp = reg_write && (reg_addr == ACSR_OFF_STEP_CMD);
    wire logic wr_code = reg_write && (reg_addr == ACSR_OFF_CODE);
    wire logic no_tbl = !sequence_table_enable;

    AST_IND_ON: assert property (wr_ind && reg_wdata[0] |=> indicator_on)
        else $error("indicator not lit");
    AST_IND_OFF: assert property (wr_ind && !reg_wdata[0] |=> !indicator_on)
        else $error("indicator not dark");
    AST_STEP_SET: assert property (wr_stp && reg_wdata[0] && cal_unlocked |=> reference_step)
        else $error("step not pending");
    AST_STEP_DONE: assert property (reference_step && reference_step_ack && !(wr_stp && reg_wdata[0])
        |=> !reference_step && reference_step_index == $past(reference_step_index) + 4'h1)
        else $error("step not cleared or counted");
    AST_STEP_LOCK: assert property (wr_stp && !cal_unlocked && !reference_step |=> !reference_step)
        else $error("step taken while locked");
    AST_CODE_GATE: assert property (!cal_unlocked |=> reference_output_code == 16'h0000)
        else $error("code out while locked");
    AST_CODE_OUT: assert property (wr_code && cal_unlocked ##1 cal_unlocked && !wr_code
        |=> reference_output_code == $past(reg_wdata, 2))
        else $error("code not driven");
    AST_RD_STATUS: assert property (reg_read && reg_addr == ACSR_OFF_STATUS
        |=> reg_rdata == {12'h000, $past(reference_step_index)})
        else $error("status read wrong");
    AST_SCAN_FIXED: assert property ((!conv_done && no_tbl) [*2] ##1 (conv_done && no_tbl) ##1 no_tbl
        |=> channel_select == $past(channel_select, 2) + 4'h1)
        else $error("fixed scan order wrong");

    // Main scenarios
    COV_UNLOCK_STEP: cover property (wr_stp && reg_wdata[0] && cal_unlocked);
    COV_ACK: cover property (reference_step && reference_step_ack);
    COV_TBL_WRAP: cover property (conv_done && table_last_entry && sequence_table_enable);
endmodule // acsr_regs_sva

bind acsr_regs acsr_regs_sva u_sva (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .indicator_on(indicator_on),
    .reference_step_ack(reference_step_ack), .reference_step(reference_step), .cal_unlocked(cal_unlocked),
    .reference_output_code(reference_output_code), .reference_step_index(reference_step_index),
    .sequence_table_enable(sequence_table_enable), .conv_done(conv_done), .channel_select(channel_select),
    .table_last_entry(table_last_entry)
);

// ===== test/acsr_regs_tb.sv
// Directed testbench for the calibration and scan register bank
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module acsr_regs_tb
    import acsr_pkg::*;
;
    localparam logic [31:0] KEY = 32'h5a5a_0f0f; // Arbitrary value
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0, reg_read = 1'b0, reference_step_ack = 1'b0, sequence_table_enable = 1'b0, conv_done = 1'b0;
    logic [15:0] reg_rdata, reference_output_code, rd_q;
    logic indicator_on, reference_step, cal_unlocked, table_last_entry;
    logic [3:0] reference_step_index, channel_select;
    int miscompares = 0;
    int total_checks = 0;
    logic [7:0] tbl [8] = '{8'h00, 8'h01, 8'h00, 8'h02, 8'h00, 8'h03, 8'h00, 8'h84};
    logic [11:0] offs [9] = '{12'h030, 12'h040, 12'h042, 12'h044, 12'h046, 12'h048, 12'h400, 12'h4ff, 12'h032};

    // Clock generator
    always #5 clock = ~clock;

    acsr_regs #(.UNLOCK_KEY(KEY)) dut (
        .clock(clock),
        .resetn(resetn),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_rdata(reg_rdata),
        .indicator_on(indicator_on),
        .reference_step_ack(reference_step_ack),
        .reference_step(reference_step),
        .cal_unlocked(cal_unlocked),
        .reference_output_code(reference_output_code),
        .reference_step_index(reference_step_index),
        .sequence_table_enable(sequence_table_enable),
        .conv_done(conv_done),
        .channel_select(channel_select),
        .table_last_entry(table_last_entry)
    );

    // ------------------------------------------------------------
    // Bus and pulse tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [15:0] e);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        rd_q = reg_rdata;
        `CHK(rd_q, e)
    endtask
    // One-cycle pulse on conversion done or step ack
    task automatic pulse(input bit conv);
        @(posedge clock);
        if (conv) conv_done <= 1'b1;
        else reference_step_ack <= 1'b1;
        @(posedge clock);
        conv_done <= 1'b0;
        reference_step_ack <= 1'b0;
        #1;
    endtask
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        foreach (offs[i]) rchk(offs[i], 16'h0000);
        $display("test reset done");
        wr(ACSR_OFF_INDICATOR, 16'h0001);
        `CHK(indicator_on, 1'b1)
        rchk(ACSR_OFF_INDICATOR, 16'h0001);
        wr(ACSR_OFF_INDICATOR, 16'hfffe);
        `CHK(indicator_on, 1'b0)
        $display("test indicator done");
        // locked, then unlocked with halves in reverse order
        wr(ACSR_OFF_CODE, 16'hbeef);
        wr(ACSR_OFF_STEP_CMD, 16'h0001);
        tick(2);
        `CHK(reference_step, 1'b0)
        `CHK(reference_output_code, 16'h0000)
        wr(ACSR_OFF_KEY_LO, KEY[15:0]);
        wr(ACSR_OFF_KEY_HI, KEY[31:16]);
        tick(2);
        `CHK(cal_unlocked, 1'b1)
        `CHK(reference_output_code, 16'hbeef)
        wr(ACSR_OFF_CODE, 16'hffff);
        tick(2);
        `CHK(reference_output_code, 16'hffff)
        $display("test key done");
        for (int i = 1; i <= 16; i++)
        begin
            wr(ACSR_OFF_STEP_CMD, 16'h0001);
            tick(1);
            `CHK(reference_step, 1'b1)
            pulse(1'b0);
            tick(1);
            `CHK(reference_step, 1'b0)
            rchk(ACSR_OFF_STATUS, 16'(i % 16));
        end
        pulse(1'b0);
        rchk(ACSR_OFF_STATUS, 16'h0000);
        wr(ACSR_OFF_STATUS, 16'hfff5);
        rchk(ACSR_OFF_STATUS, 16'h0005);
        `CHK(reference_step_index, 4'h5)
        wr(ACSR_OFF_KEY_LO, ~KEY[15:0]);
        tick(2);
        `CHK(cal_unlocked, 1'b0)
        `CHK(reference_output_code, 16'h0000)
        $display("test steps done");
        // table of eight, reserved bits zero
        foreach (tbl[i]) wr(ACSR_OFF_TABLE_BASE + 12'(i), {8'h00, tbl[i]});
        wr(ACSR_OFF_TABLE_LAST, 16'hff05);
        rchk(ACSR_OFF_TABLE_LAST, 16'h0005);
        rchk(ACSR_OFF_TABLE_BASE + 12'h007, 16'h0084);
        @(posedge clock);
        sequence_table_enable <= 1'b1;
        tick(3);
        for (int i = 0; i <= 16; i++)
        begin
            `CHK(channel_select, tbl[i % 8][3:0])
            `CHK(table_last_entry, tbl[i % 8][7])
            pulse(1'b1);
            tick(1);
        end
        @(posedge clock);
        sequence_table_enable <= 1'b0;
        tick(3);
        for (int i = 0; i <= 16; i++)
        begin
            `CHK(channel_select, 4'(i))
            `CHK(table_last_entry, (i % 16 == 15))
            pulse(1'b1);
            tick(1);
        end
        $display("test scan done");
        report_and_stop();
    end

    // Watchdog against a hang
    initial
    begin
        #200000;
        miscompares++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule // acsr_regs_tb
